// *** design/aaifm_entry_if.sv ***
`timescale 1ns/1ps
// Carries one entry's settings and one parsed frame to the evaluator.
interface aaifm_entry_if;
	// Entry settings.
	logic [1:0] frame_type;
	logic proto_spec;
	logic [7:0] proto_val;
	logic [aaifm_pkg::ARP_BITS-1:0] arp_cfg;
	logic [47:0] tmac;
	logic type_spec;
	logic [7:0] type_val;
	logic code_spec;
	logic [7:0] code_val;
	// Parsed frame fields.
	logic is_arp;
	logic is_rarp;
	logic is_ipv4;
	logic [15:0] op;
	logic [47:0] sha;
	logic [47:0] smac;
	logic [47:0] tha;
	logic [7:0] hln;
	logic [7:0] pln;
	logic [15:0] hrd;
	logic [15:0] pro;
	logic [7:0] ip_proto;
	logic [7:0] icmp_type;
	logic [7:0] icmp_code;
	// Verdict.
	logic hit;

	modport src (
		output frame_type, proto_spec, proto_val, arp_cfg, tmac,
		output type_spec, type_val, code_spec, code_val,
		output is_arp, is_rarp, is_ipv4, op, sha, smac, tha,
		output hln, pln, hrd, pro, ip_proto, icmp_type, icmp_code,
		input hit
	);
	modport eval (
		input frame_type, proto_spec, proto_val, arp_cfg, tmac,
		input type_spec, type_val, code_spec, code_val,
		input is_arp, is_rarp, is_ipv4, op, sha, smac, tha,
		input hln, pln, hrd, pro, ip_proto, icmp_type, icmp_code,
		output hit
	);
endinterface : aaifm_entry_if

// *** design/aaifm_eval.sv ***
`timescale 1ns/1ps
// Combinational verdict of one entry against one frame.
module aaifm_eval (
	// Settings and frame in, verdict out.
	aaifm_entry_if.eval e
);
	// Either resolution protocol counts as an ARP-family frame.
	wire arp_fam = e.is_arp | e.is_rarp;
	wire [1:0] s_smac = e.arp_cfg[aaifm_pkg::ARP_SMAC_LSB +: 2];
	wire [1:0] s_tmac = e.arp_cfg[aaifm_pkg::ARP_TMAC_LSB +: 2];
	wire [1:0] s_len = e.arp_cfg[aaifm_pkg::ARP_LEN_LSB +: 2];
	wire [1:0] s_hrd = e.arp_cfg[aaifm_pkg::ARP_HRD_LSB +: 2];
	wire [1:0] s_pro = e.arp_cfg[aaifm_pkg::ARP_PRO_LSB +: 2];
	wire [1:0] s_op = e.arp_cfg[aaifm_pkg::ARP_OP_LSB +: 2];
	wire [1:0] s_rr = e.arp_cfg[aaifm_pkg::ARP_RR_LSB +: 2];

	// Sender check applies to ARP frames only; others pass it.
	wire smac_ok = !e.is_arp ||
		aaifm_pkg::tri_pass(s_smac, e.sha == e.smac);
	// Target check applies to RARP frames only.
	wire tmac_ok = !e.is_rarp ||
		aaifm_pkg::tri_pass(s_tmac, e.tha == e.tmac);
	wire len_q = (e.hln == aaifm_pkg::HLN_ETH) &&
		(e.pln == aaifm_pkg::PLN_IPV4);
	wire len_ok = aaifm_pkg::tri_pass(s_len, len_q);
	wire hrd_ok = aaifm_pkg::tri_pass(s_hrd,
		e.hrd == aaifm_pkg::HRD_ETH);
	wire pro_ok = aaifm_pkg::tri_pass(s_pro,
		e.pro == aaifm_pkg::PRO_IP);

	// Opcode classes; anything outside the four known codes is other.
	wire op_arp = (e.op == aaifm_pkg::OP_ARP_REQ) ||
		(e.op == aaifm_pkg::OP_ARP_REP);
	wire op_rarp = (e.op == aaifm_pkg::OP_RARP_REQ) ||
		(e.op == aaifm_pkg::OP_RARP_REP);
	wire op_req = (e.op == aaifm_pkg::OP_ARP_REQ) ||
		(e.op == aaifm_pkg::OP_RARP_REQ);
	wire op_rep = (e.op == aaifm_pkg::OP_ARP_REP) ||
		(e.op == aaifm_pkg::OP_RARP_REP);
	wire op_ok = (s_op == aaifm_pkg::OPS_ANY) ||
		((s_op == aaifm_pkg::OPS_ARP) && op_arp) ||
		((s_op == aaifm_pkg::OPS_RARP) && op_rarp) ||
		((s_op == aaifm_pkg::OPS_OTHER) && !op_arp && !op_rarp);
	wire rr_ok = (s_rr == aaifm_pkg::RR_ANY) ||
		((s_rr == aaifm_pkg::RR_REQ) && op_req) ||
		((s_rr == aaifm_pkg::RR_REP) && op_rep) ||
		(s_rr == aaifm_pkg::RR_ALL);

	// All ARP criteria together, only when the entry selects ARP.
	wire arp_sel = (e.frame_type == aaifm_pkg::FT_ARP);
	wire arp_ok = !arp_sel || (arp_fam && smac_ok && tmac_ok &&
		len_ok && hrd_ok && pro_ok && op_ok && rr_ok);

	// IPv4 frames with an optional protocol compare.
	wire ip_sel = (e.frame_type == aaifm_pkg::FT_IPV4);
	wire proto_ok = !e.proto_spec || (e.ip_proto == e.proto_val);
	// ICMP fields only count for an IPv4 entry pinned to ICMP.
	wire icmp_sel = ip_sel && e.proto_spec &&
		(e.proto_val == aaifm_pkg::IPPROTO_ICMP);
	wire type_ok = !e.type_spec || (e.icmp_type == e.type_val);
	wire code_ok = !e.code_spec || (e.icmp_code == e.code_val);
	wire icmp_ok = !icmp_sel || (type_ok && code_ok);
	wire ip_ok = !ip_sel || (e.is_ipv4 && proto_ok && icmp_ok);

	// Any other frame type code is treated as any frame.
	assign e.hit = arp_ok && ip_ok;
endmodule // aaifm_eval

// *** design/aaifm_pkg.sv ***
// What this block does
// - RARP target hardware address versus configured MAC.
// - Lengths 0x06/0x04 qualify; tri-state select.
// - Hardware space equals Ethernet 1; tri-state.
// - Protocol space equals IP 0x800; tri-state.
// - ICMP checks only for IPv4 with ICMP.
// - ICMP type any or exact compare.
// - ICMP type value is eight bits.
// - ICMP code any or exact compare.
// - ICMP code value is eight bits.
// - ARP sender address versus source MAC.
// - Opcode class and request/reply selections.
package aaifm_pkg;

	// Register byte offsets on the AHB-Lite bus.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ARP = 8'h04;
	localparam logic [7:0] OFS_TMAC_LO = 8'h08;
	localparam logic [7:0] OFS_TMAC_HI = 8'h0C;
	localparam logic [7:0] OFS_ICMP = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_HITS = 8'h18;
	// Address bits that select a word inside the register map.
	localparam int MAP_BITS = 8;

	// Tri-state setting codes; both upper codes mean don't-care.
	localparam logic [1:0] TRI_ZERO = 2'h0;
	localparam logic [1:0] TRI_ONE = 2'h1;
	localparam logic [1:0] TRI_ANY = 2'h2;

	// Frame type selection codes.
	localparam logic [1:0] FT_ANY = 2'h0;
	localparam logic [1:0] FT_ARP = 2'h1;
	localparam logic [1:0] FT_IPV4 = 2'h2;

	// Opcode class selection codes.
	localparam logic [1:0] OPS_ANY = 2'h0;
	localparam logic [1:0] OPS_ARP = 2'h1;
	localparam logic [1:0] OPS_RARP = 2'h2;
	localparam logic [1:0] OPS_OTHER = 2'h3;

	// Request/reply selection codes.
	localparam logic [1:0] RR_ANY = 2'h0;
	localparam logic [1:0] RR_REQ = 2'h1;
	localparam logic [1:0] RR_REP = 2'h2;
	localparam logic [1:0] RR_ALL = 2'h3;

	// Header constants of the address resolution protocols.
	localparam logic [7:0] HLN_ETH = 8'h06;
	localparam logic [7:0] PLN_IPV4 = 8'h04;
	localparam logic [15:0] HRD_ETH = 16'h0001;
	localparam logic [15:0] PRO_IP = 16'h0800;
	localparam logic [15:0] OP_ARP_REQ = 16'h0001;
	localparam logic [15:0] OP_ARP_REP = 16'h0002;
	localparam logic [15:0] OP_RARP_REQ = 16'h0003;
	localparam logic [15:0] OP_RARP_REP = 16'h0004;
	localparam logic [7:0] IPPROTO_ICMP = 8'h01;

	// Field positions inside the ARP settings register.
	localparam int ARP_SMAC_LSB = 0;
	localparam int ARP_TMAC_LSB = 2;
	localparam int ARP_LEN_LSB = 4;
	localparam int ARP_HRD_LSB = 6;
	localparam int ARP_PRO_LSB = 8;
	localparam int ARP_OP_LSB = 10;
	localparam int ARP_RR_LSB = 12;
	localparam int ARP_BITS = 14;

	// Field positions inside the control and ICMP registers.
	localparam int CTRL_FT_LSB = 0;
	localparam int CTRL_PROTO_LSB = 8;
	localparam int CTRL_PROTO_SPEC = 16;
	localparam int CTRL_BITS = 17;
	localparam int ICMP_TYPE_LSB = 0;
	localparam int ICMP_TYPE_SPEC = 8;
	localparam int ICMP_CODE_LSB = 16;
	localparam int ICMP_CODE_SPEC = 24;
	localparam int ICMP_BITS = 25;

	// Reset values: the opcode class starts as RARP; every other criterion starts as don't-care.
	localparam logic [ARP_BITS-1:0] ARP_RST = 14'h0AAA;
	localparam logic [CTRL_BITS-1:0] CTRL_RST = 17'h00000;
	localparam logic [ICMP_BITS-1:0] ICMP_RST = 25'h0000000;

	// Passes when the setting is don't-care or equals the tested condition.
	function automatic logic tri_pass(input logic [1:0] sel, input logic cond);
		tri_pass = sel[1] | (sel[0] == cond);
	endfunction

endpackage : aaifm_pkg

// *** design/aaifm_top.sv ***
`timescale 1ns/1ps
// One access-control entry for ARP/RARP and ICMP fields, with its
// settings held in AHB-Lite registers and a registered verdict.
module aaifm_top (
	// Clock and synchronous reset.
	input wire logic mclk,
	input wire logic rst,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Parsed frame from the ingress parser, same clock.
	input wire logic frm_valid,
	input wire logic frm_is_arp,
	input wire logic frm_is_rarp,
	input wire logic frm_is_ipv4,
	input wire logic [15:0] frm_op,
	input wire logic [47:0] frm_sha,
	input wire logic [47:0] frm_smac,
	input wire logic [47:0] frm_tha,
	input wire logic [7:0] frm_hln,
	input wire logic [7:0] frm_pln,
	input wire logic [15:0] frm_hrd,
	input wire logic [15:0] frm_pro,
	input wire logic [7:0] frm_ip_proto,
	input wire logic [7:0] frm_icmp_type,
	input wire logic [7:0] frm_icmp_code,
	// Verdict, one cycle after the frame strobe.
	output logic match_valid,
	output logic match_hit
);
	// Settings registers.
	logic [aaifm_pkg::CTRL_BITS-1:0] ctrl_q;
	logic [aaifm_pkg::ARP_BITS-1:0] arp_q;
	// The target MAC spans two words; the high word keeps 16 bits.
	logic [31:0] tmac_lo_q;
	logic [15:0] tmac_hi_q;
	logic [aaifm_pkg::ICMP_BITS-1:0] icmp_q;
	// Verdict and statistics.
	// Hits count from reset or from the last write to the hits word.
	logic mvalid_q;
	logic mhit_q;
	logic seen_q;
	logic [31:0] hits_q;
	// Bus data phase state.
	// A write lands one cycle after its address phase, in its data phase.
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] rdata_q;

	// The entry evaluator sees settings and frame through one bundle.
	aaifm_entry_if ent ();

	// Settings side of the bundle, sliced out of the registers.
	assign ent.frame_type = ctrl_q[aaifm_pkg::CTRL_FT_LSB +: 2];
	assign ent.proto_spec = ctrl_q[aaifm_pkg::CTRL_PROTO_SPEC];
	assign ent.proto_val = ctrl_q[aaifm_pkg::CTRL_PROTO_LSB +: 8];
	assign ent.arp_cfg = arp_q;
	assign ent.tmac = {tmac_hi_q, tmac_lo_q};
	assign ent.type_spec = icmp_q[aaifm_pkg::ICMP_TYPE_SPEC];
	assign ent.type_val = icmp_q[aaifm_pkg::ICMP_TYPE_LSB +: 8];
	assign ent.code_spec = icmp_q[aaifm_pkg::ICMP_CODE_SPEC];
	assign ent.code_val = icmp_q[aaifm_pkg::ICMP_CODE_LSB +: 8];
	// Frame side of the bundle. The parser runs on this clock, so its
	// fields feed the evaluator with no synchroniser in between.
	assign ent.is_arp = frm_is_arp;
	assign ent.is_rarp = frm_is_rarp;
	assign ent.is_ipv4 = frm_is_ipv4;
	assign ent.op = frm_op;
	assign ent.sha = frm_sha;
	assign ent.smac = frm_smac;
	assign ent.tha = frm_tha;
	assign ent.hln = frm_hln;
	assign ent.pln = frm_pln;
	assign ent.hrd = frm_hrd;
	assign ent.pro = frm_pro;
	assign ent.ip_proto = frm_ip_proto;
	assign ent.icmp_type = frm_icmp_type;
	assign ent.icmp_code = frm_icmp_code;

	// The verdict logic lives in its own module.
	// It is purely combinational, so the verdict flop and the hit counter
	// below close the timing paths that start at the frame fields.
	aaifm_eval u_eval (
		.e(ent.eval)
	);

	// Address phase decode; only NONSEQ or SEQ with hready counts.
	// A BUSY or IDLE cycle has htrans[1] low and is ignored here.
	wire addr_ok = hsel && htrans[1] && hready;
	// Word offset inside the map; the two byte bits are ignored because
	// only whole aligned words are supported.
	wire [7:0] aofs = {haddr[aaifm_pkg::MAP_BITS-1:2], 2'h0};
	// Any address bit above the map makes the access unmapped.
	wire above = |haddr[31:aaifm_pkg::MAP_BITS];
	// Writes and reads split here so each path has its own strobe.
	wire wr_take = addr_ok && hwrite;
	wire rd_take = addr_ok && !hwrite;
	// Read mux; unmapped offsets read as zero.
	// Holes read as zero rather than as an alias, so software probing
	// the map never mistakes a hole for a live register.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		if (!above) begin
			case (aofs)
				aaifm_pkg::OFS_CTRL: rd_mux = 32'(ctrl_q);
				aaifm_pkg::OFS_ARP: rd_mux = 32'(arp_q);
				aaifm_pkg::OFS_TMAC_LO: rd_mux = tmac_lo_q;
				aaifm_pkg::OFS_TMAC_HI: rd_mux = 32'(tmac_hi_q);
				aaifm_pkg::OFS_ICMP: rd_mux = 32'(icmp_q);
				// Status packs the seen flag above the last verdict.
				aaifm_pkg::OFS_STATUS: rd_mux = {30'h0, seen_q, mhit_q};
				aaifm_pkg::OFS_HITS: rd_mux = hits_q;
				default: rd_mux = 32'h00000000;
			endcase
		end
	end

	// The slave never stretches a transfer and never errors.
	// Every register answers in one cycle, so a wait state would only
	// cost bus bandwidth and buy nothing.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;

	// Read data is captured at the address phase for the data phase.
	// The trade-off: hrdata is a flop, but a read in the data phase of
	// a write to the same register returns the old value.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= 32'h00000000;
		end else if (rd_take) begin
			rdata_q <= rd_mux;
		end
	end

	// Remember a write's address until its data phase.
	// The address is copied every cycle; only wr_pend_q says whether
	// the copy belongs to a write that was really taken.
	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= wr_take && !above;
			wr_addr_q <= aofs;
		end
	end

	// Write strobes per register; writes elsewhere are dropped.
	// Status is read-only, so a write there decodes to no strobe.
	wire we_ctrl = wr_pend_q && (wr_addr_q == aaifm_pkg::OFS_CTRL);
	wire we_arp = wr_pend_q && (wr_addr_q == aaifm_pkg::OFS_ARP);
	wire we_tlo = wr_pend_q && (wr_addr_q == aaifm_pkg::OFS_TMAC_LO);
	wire we_thi = wr_pend_q && (wr_addr_q == aaifm_pkg::OFS_TMAC_HI);
	wire we_icmp = wr_pend_q && (wr_addr_q == aaifm_pkg::OFS_ICMP);
	wire we_hits = wr_pend_q && (wr_addr_q == aaifm_pkg::OFS_HITS);

	// Settings take hwdata in the write's data phase.
	// Bits of hwdata beyond each register's width are dropped, so bits
	// above that width always read back as zero.
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_q <= aaifm_pkg::CTRL_RST;
			arp_q <= aaifm_pkg::ARP_RST;
			tmac_lo_q <= 32'h00000000;
			tmac_hi_q <= 16'h0000;
			icmp_q <= aaifm_pkg::ICMP_RST;
		end else begin
			if (we_ctrl) ctrl_q <= hwdata[aaifm_pkg::CTRL_BITS-1:0];
			if (we_arp) arp_q <= hwdata[aaifm_pkg::ARP_BITS-1:0];
			if (we_tlo) tmac_lo_q <= hwdata;
			if (we_thi) tmac_hi_q <= hwdata[15:0];
			if (we_icmp) icmp_q <= hwdata[aaifm_pkg::ICMP_BITS-1:0];
		end
	end

	// Verdict register; a frame strobe always yields one verdict.
	// match_valid follows frm_valid exactly one cycle later, and
	// match_hit holds between frames so status shows the last verdict.
	always_ff @(posedge mclk) begin
		if (rst) begin
			mvalid_q <= 1'b0;
			mhit_q <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			mvalid_q <= frm_valid;
			if (frm_valid) begin
				mhit_q <= ent.hit;
				seen_q <= 1'b1;
			end
		end
	end

	// Hit counter; a new hit in the clearing cycle is still counted,
	// because losing a hit would skew statistics more than a late one.
	// Any write to the hits word clears it; the written data is ignored.
	always_ff @(posedge mclk) begin
		if (rst) begin
			hits_q <= 32'h00000000;
		end else if (we_hits) begin
			hits_q <= {31'h0, frm_valid && ent.hit};
		end else if (frm_valid && ent.hit) begin
			hits_q <= hits_q + 32'h00000001;
		end
	end

	// Both verdict outputs are plain flop copies, free of glitches.
	assign match_valid = mvalid_q;
	assign match_hit = mhit_q;

	// Unused in a word-only slave; kept on the port for bus fidelity.
	// Narrow accesses are not supported; software must use words.
	wire unused_size = ^hsize;
endmodule // aaifm_top

// *** tb/aaifm_checker_asserts.sv ***
`timescale 1ns/1ps
// Verdict timing, bus answer and frame-type gates seen at the ports.
module aaifm_checker (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Bus.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Frame and verdict.
	input wire logic frm_valid,
	input wire logic frm_is_arp,
	input wire logic frm_is_rarp,
	input wire logic frm_is_ipv4,
	input wire logic match_valid,
	input wire logic match_hit
);
	wire take = hsel & htrans[1] & hready;
	logic wr_ctrl_q;
	logic [1:0] ft_q;
	// Shadow of the frame-type field, kept so gates can be judged here.
	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_ctrl_q <= 1'b0;
			ft_q <= 2'h0;
		end else begin
			wr_ctrl_q <= take & hwrite & (haddr == 32'h0);
			if (wr_ctrl_q) begin
				ft_q <= hwdata[1:0];
			end
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	a_verdict_next: assert property (frm_valid |=> match_valid)
		else $error("verdict strobe missing");
	a_no_spurious: assert property (!frm_valid |=> !match_valid)
		else $error("verdict strobe without frame");
	a_hit_holds: assert property (!frm_valid |=> $stable(match_hit))
		else $error("verdict changed without frame");
	a_ready_high: assert property (hreadyout == 1'b1)
		else $error("wait state inserted");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response");
	a_any_hits: assert property (frm_valid && ft_q[0] == ft_q[1]
		|=> match_hit)
		else $error("don't-care entry missed");
	a_ipv4_gate: assert property (frm_valid && ft_q == 2'h2
		&& !frm_is_ipv4 |=> !match_hit)
		else $error("non IPv4 frame hit");
	a_arp_gate: assert property (frm_valid && ft_q == 2'h1
		&& !(frm_is_arp | frm_is_rarp) |=> !match_hit)
		else $error("non ARP frame hit");
	a_unmapped_zero: assert property (take && !hwrite
		&& haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	c_hit: cover property (frm_valid ##1 match_hit);
	c_miss: cover property (frm_valid ##1 !match_hit);
	c_write: cover property (wr_ctrl_q);
endmodule // aaifm_checker

bind aaifm_top aaifm_checker i_aaifm_checker (.mclk(mclk), .rst(rst),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .frm_valid(frm_valid),
	.frm_is_arp(frm_is_arp), .frm_is_rarp(frm_is_rarp),
	.frm_is_ipv4(frm_is_ipv4), .match_valid(match_valid),
	.match_hit(match_hit));

// *** tb/aaifm_parser_model.sv ***
`timescale 1ns/1ps
// Ingress parser stand-in: presents one frame a cycle on request.
module aaifm_parser_model (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Request from the bench.
	input wire logic send,
	input wire logic [234:0] fields,
	// Parsed frame toward the entry.
	output logic frm_valid,
	output logic [234:0] frm_bus
);
	initial begin
		frm_valid = 1'b0;
		frm_bus = 235'h0;
	end
	// Idle fields flip to their inverse every cycle, so a stale
	// sample in the entry cannot pass for a real one.
	always @(posedge mclk) begin
		frm_valid <= rst ? 1'b0 : send;
		frm_bus <= send ? fields : ~frm_bus;
	end
endmodule // aaifm_parser_model

// *** tb/aaifm_top_tb.sv ***
`timescale 1ns/1ps
// Random settings and frames; a queue model predicts every verdict.
module aaifm_top_tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic send = 1'b0;
	logic [234:0] fields = 235'h0;
	wire [31:0] hrdata;
	wire hreadyout, hresp, frm_valid, match_valid, match_hit;
	wire [234:0] fb;
	int err_count = 0;
	int n_tests = 0;
	logic [31:0] x = 32'h3F;
	logic [31:0] ctl, arp, icm, rd, r;
	logic [31:0] ev;
	logic [47:0] tm;
	logic [234:0] f;
	bit q[$];
	bit lastv;
	int hits = 0;
	aaifm_top i_aaifm_top (.mclk(mclk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .frm_valid(frm_valid),
		.frm_is_arp(fb[234]), .frm_is_rarp(fb[233]),
		.frm_is_ipv4(fb[232]), .frm_op(fb[231:216]),
		.frm_sha(fb[215:168]), .frm_smac(fb[167:120]),
		.frm_tha(fb[119:72]), .frm_hln(fb[71:64]), .frm_pln(fb[63:56]),
		.frm_hrd(fb[55:40]), .frm_pro(fb[39:24]),
		.frm_ip_proto(fb[23:16]), .frm_icmp_type(fb[15:8]),
		.frm_icmp_code(fb[7:0]), .match_valid(match_valid),
		.match_hit(match_hit));
	aaifm_parser_model i_aaifm_parser_model (.mclk(mclk), .rst(rst),
		.send(send), .fields(fields), .frm_valid(frm_valid),
		.frm_bus(fb));
	initial begin
		forever #20 mclk = ~mclk;
	end
	function automatic logic [31:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// Tri-state setting: codes above one are don't-care.
	function automatic bit tp(int k, bit c);
		int s = (arp >> k) & 3;
		return s > 1 || s == int'(c);
	endfunction
	// Verdict the entry should give for frame f under the settings.
	function automatic bit exp_hit();
		int op = f[231:216];
		int os = (arp >> 10) & 3;
		int rs = (arp >> 12) & 3;
		bit opok = os == 0 || (os == 1 && (op == 1 || op == 2))
			|| (os == 2 && (op == 3 || op == 4)) || (os == 3 && (op < 1 || op > 4));
		bit rrok = rs == 0 || rs == 3 || (rs == 1 && (op == 1 || op == 3))
			|| (rs == 2 && (op == 2 || op == 4));
		bit icok = (!icm[8] || f[15:8] == icm[7:0])
			&& (!icm[24] || f[7:0] == icm[23:16]);
		case (ctl[1:0])
			2'h1: return (f[234] | f[233]) && opok && rrok
				&& (!f[234] || tp(0, f[215:168] == f[167:120]))
				&& (!f[233] || tp(2, f[119:72] == tm))
				&& tp(4, f[71:64] == 8'h06 && f[63:56] == 8'h04)
				&& tp(6, f[55:40] == 16'h0001) && tp(8, f[39:24] == 16'h0800);
			2'h2: return f[232] && (!ctl[16] || f[23:16] == ctl[15:8])
				&& (!(ctl[16] && ctl[15:8] == 8'h01) || icok);
			default: return 1'b1;
		endcase
	endfunction
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: exp %h got %h", $time, e, g);
		end
	endtask
	// Verdict compare: the expected bit against the registered verdict.
	task automatic chk_v(input logic [31:0] e);
		chk(e, 32'(match_hit));
	endtask
	// One single AHB-Lite transfer; read data taken at the data edge.
	task automatic xfer(input logic [31:0] a, input bit w,
		input logic [31:0] d, output logic [31:0] o);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		o = hrdata;
	endtask
	task automatic stop_test();
		$display("Counts: %0d mismatches, %0d checks", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Each verdict is compared with the oldest prediction; a verdict
	// with no prediction behind it is always a mismatch.
	always @(posedge mclk) begin
		if (match_valid === 1'b1) begin
			ev = q.size() > 0 ? 32'(q.pop_front()) : 32'h2;
			chk_v(ev);
		end
	end
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		// Reset values leave every criterion but the opcode class don't-care; 0x100 is unmapped.
		for (int i = 0; i < 8; i++) begin
			xfer(i == 7 ? 32'h100 : 32'(i * 4), 1'b0, 32'h0, rd);
			chk(i == 1 ? 32'h0AAA : 32'h0, rd);
		end
		for (int n = 0; n < 150; n++) begin
			r = rnd();
			ctl = {15'h0, r[2], (r[3] ? 8'h01 : 8'h06), 6'h0, r[1:0]};
			arp = rnd() & 32'h3FFF;
			tm = 48'({rnd(), rnd()});
			icm = {7'h0, r[4], (r[5] ? 8'hFF : 8'h03), 7'h0, r[6],
				(r[7] ? 8'hFF : 8'h00)};
			xfer(32'h0, 1'b1, ctl, rd);
			xfer(32'h4, 1'b1, arp, rd);
			xfer(32'h8, 1'b1, tm[31:0], rd);
			xfer(32'hC, 1'b1, {16'h0, tm[47:32]}, rd);
			xfer(32'h10, 1'b1, icm, rd);
			// Four frames back to back under the same settings.
			for (int k = 0; k < 4; k++) begin
				r = rnd();
				f = {r[1:0] == 2'h0, r[1:0] == 2'h1, r[1:0] == 2'h2,
					13'h0, r[4:2], (r[5] ? 48'h0A0B0C0D0E0F : 48'h0A0B0C0D0E0E),
					48'h0A0B0C0D0E0F, (r[6] ? tm : ~tm), (r[7] ? 8'h06 : 8'h05),
					(r[8] ? 8'h04 : 8'h08), (r[9] ? 16'h0001 : 16'h0006),
					(r[10] ? 16'h0800 : 16'h86DD), (r[11] ? 8'h01 : 8'h06),
					(r[12] ? 8'hFF : 8'h00), (r[13] ? 8'hFF : 8'h03)};
				lastv = exp_hit();
				q.push_back(lastv);
				hits += int'(lastv);
				@(posedge mclk);
				send <= 1'b1;
				fields <= f;
			end
			@(posedge mclk);
			send <= 1'b0;
			repeat (4) @(posedge mclk);
		end
		xfer(32'h18, 1'b0, 32'h0, rd);
		chk(32'(hits), rd);
		xfer(32'h14, 1'b0, 32'h0, rd);
		chk({30'h0, 1'b1, lastv}, rd);
		xfer(32'h18, 1'b1, 32'h0, rd);
		xfer(32'h18, 1'b0, 32'h0, rd);
		chk(32'h0, rd);
		stop_test();
	end
	// Watchdog well beyond the roughly 3600 cycles the run needs.
	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		stop_test();
	end
endmodule // aaifm_top_tb
